// ===== rtl/serial_fifo_port_control.sv
module serial_fifo_port_control
    import serial_fifo_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        transmitter_enable,
    input  wire logic [1:0]  clk_source_sel,
    input  wire logic        tx_serial_in,
    input  wire logic        tx_take,
    output logic      [7:0]  tx_byte,
    output logic             tx_byte_valid,
    output logic             tx_allowed,
    input  wire logic        rx_done,
    input  wire logic [7:0]  rx_byte,
    output logic             rx_serial_out,
    output logic             rx_full_flag,
    output logic             tx_empty_flag,
    input  wire logic        rxd_pin,
    output logic             txd_pin,
    output logic             rts_pin_out,
    output logic             rts_pin_oe_n,
    input  wire logic        cts_pin_in,
    output logic             cts_pin_out,
    output logic             cts_pin_oe_n,
    output logic             sck_pin_out,
    output logic             sck_pin_oe_n
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------

    logic rxd_meta;
    logic rxd_sync;
    logic cts_meta;
    logic cts_sync;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
            cts_meta <= 1'b0;
            cts_sync <= 1'b0;
        end
        else
        begin
            rxd_meta <= rxd_pin;
            rxd_sync <= rxd_meta;
            cts_meta <= cts_pin_in;
            cts_sync <= cts_meta;
        end
    end

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------

    fifo_control_type     fifo_control;
    pin_port_control_type pin_port_control;
    logic                 overrun_flag;
    logic                 overrun_armed;
    logic                 rx_pop_armed;
    logic [4:0]           tx_count;
    logic [4:0]           rx_count;
    logic [7:0]           rx_head;

    wire logic setup_phase   = psel && !penable;
    wire logic access_phase  = psel && penable;
    wire logic hit_tx_data   = paddr == ADDR_TX_DATA;
    wire logic hit_rx_data   = paddr == ADDR_RX_DATA;
    wire logic hit_control   = paddr == ADDR_FIFO_CONTROL;
    wire logic hit_fill      = paddr == ADDR_FILL_COUNT;
    wire logic hit_port      = paddr == ADDR_PORT_CONTROL;
    wire logic hit_status    = paddr == ADDR_LINE_STATUS;
    wire logic mapped        = hit_tx_data || hit_rx_data || hit_control
                               || hit_fill || hit_port || hit_status;
    wire logic write_access  = access_phase && pwrite && mapped;
    wire logic read_access   = access_phase && !pwrite && mapped;

    assign pready  = 1'b1;
    assign pslverr = access_phase && !mapped;

    // Byte-lane merge of a 16-bit register with the write strobes.
    function automatic logic [15:0] merge_lanes(input logic [15:0] old_value,
                                                input logic [31:0] new_value,
                                                input logic [3:0]  lanes);
        logic [15:0] result;
        result       = old_value;
        if (lanes[0])
        begin
            result[7:0] = new_value[7:0];
        end
        if (lanes[1])
        begin
            result[15:8] = new_value[15:8];
        end
        return result;
    endfunction

    // ---------------------------------------------------------------
    // Control and port registers
    // ---------------------------------------------------------------

    fifo_control_type     next_fifo_control;
    pin_port_control_type next_pin_port_control;
    logic [15:0]          merged_control;
    logic [15:0]          merged_port;

    assign merged_control        = merge_lanes(fifo_control, pwdata, pstrb);
    assign merged_port           = merge_lanes(pin_port_control, pwdata, pstrb);
    assign next_fifo_control     = fifo_control_type'({5'h00, merged_control[10:0]});
    assign next_pin_port_control = pin_port_control_type'({8'h00, merged_port[7:0]});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_control     <= fifo_control_type'(FIFO_CONTROL_RESET);
            pin_port_control <= pin_port_control_type'(PORT_CONTROL_RESET);
        end
        else
        begin
            if (write_access && hit_control)
            begin
                fifo_control <= next_fifo_control;
            end
            if (write_access && hit_port)
            begin
                pin_port_control <= next_pin_port_control;
            end
        end
    end

    // ---------------------------------------------------------------
    // Transmit queue
    // ---------------------------------------------------------------

    logic [PTR_WIDTH-1:0] tx_wr_ptr;
    logic [PTR_WIDTH-1:0] tx_rd_ptr;
    logic [PTR_WIDTH-1:0] next_tx_rd_ptr;

    wire logic tx_clear = fifo_control.tx_fifo_clear;
    wire logic tx_push  = write_access && hit_tx_data && pstrb[0]
                          && tx_count != FIFO_FULL_COUNT && !tx_clear;
    wire logic tx_pop   = tx_take && tx_count != 5'h00 && !tx_clear;

    assign next_tx_rd_ptr = tx_clear ? '0 : tx_rd_ptr + PTR_WIDTH'(tx_pop);
    assign tx_byte_valid  = tx_count != 5'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_wr_ptr <= '0;
            tx_rd_ptr <= '0;
            tx_count  <= 5'h00;
        end
        else if (tx_clear)
        begin
            tx_wr_ptr <= '0;
            tx_rd_ptr <= '0;
            tx_count  <= 5'h00;
        end
        else
        begin
            tx_wr_ptr <= tx_wr_ptr + PTR_WIDTH'(tx_push);
            tx_rd_ptr <= next_tx_rd_ptr;
            tx_count  <= tx_count + 5'(tx_push) - 5'(tx_pop);
        end
    end

    byte_fifo_mem tx_store
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .write_en   (tx_push),
        .write_addr (tx_wr_ptr),
        .write_data (pwdata[7:0]),
        .read_addr  (next_tx_rd_ptr),
        .read_data  (tx_byte)
    );

    // ---------------------------------------------------------------
    // Receive queue
    // ---------------------------------------------------------------

    logic [PTR_WIDTH-1:0] rx_wr_ptr;
    logic [PTR_WIDTH-1:0] rx_rd_ptr;
    logic [PTR_WIDTH-1:0] next_rx_rd_ptr;

    wire logic rx_clear   = fifo_control.rx_fifo_clear;
    wire logic rx_is_full = rx_count == FIFO_FULL_COUNT;
    wire logic rx_push    = rx_done && !rx_is_full && !rx_clear;
    wire logic rx_overrun = rx_done && rx_is_full;
    wire logic rx_pop     = read_access && hit_rx_data && rx_pop_armed
                            && !rx_clear;

    assign next_rx_rd_ptr = rx_clear ? '0 : rx_rd_ptr + PTR_WIDTH'(rx_pop);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_wr_ptr <= '0;
            rx_rd_ptr <= '0;
            rx_count  <= 5'h00;
        end
        else if (rx_clear)
        begin
            rx_wr_ptr <= '0;
            rx_rd_ptr <= '0;
            rx_count  <= 5'h00;
        end
        else
        begin
            rx_wr_ptr <= rx_wr_ptr + PTR_WIDTH'(rx_push);
            rx_rd_ptr <= next_rx_rd_ptr;
            rx_count  <= rx_count + 5'(rx_push) - 5'(rx_pop);
        end
    end

    byte_fifo_mem rx_store
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .write_en   (rx_push),
        .write_addr (rx_wr_ptr),
        .write_data (rx_byte),
        .read_addr  (next_rx_rd_ptr),
        .read_data  (rx_head)
    );

    // ---------------------------------------------------------------
    // Overrun flag
    // ---------------------------------------------------------------

    // The flag is armed for clearing only by a read that returned it as one.
    wire logic status_write = write_access && hit_status && pstrb[0];
    wire logic overrun_clear = status_write && !pwdata[OVERRUN_BIT]
                               && overrun_armed;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overrun_flag  <= 1'b0;
            overrun_armed <= 1'b0;
        end
        else
        begin
            overrun_flag <= rx_overrun || (overrun_flag && !overrun_clear);
            if (status_write || !overrun_flag)
            begin
                overrun_armed <= 1'b0;
            end
            else if (read_access && hit_status && prdata[OVERRUN_BIT])
            begin
                overrun_armed <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------

    logic [31:0] read_value;
    logic [15:0] fill_value;
    logic [15:0] port_value;

    assign fill_value = {3'h0, tx_count, 3'h0, rx_count};
    assign port_value = {pin_port_control[15:1], rxd_sync};
    assign read_value = hit_control ? {16'h0000, fifo_control}
                      : hit_fill    ? {16'h0000, fill_value}
                      : hit_port    ? {16'h0000, port_value}
                      : hit_status  ? {31'h0000_0000, overrun_flag}
                      : hit_rx_data ? {24'h00_0000, rx_head}
                      : 32'h0000_0000;

    // Read data is captured in the setup cycle, so the access phase
    // presents a registered value and a receive pop matches what was shown.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata       <= 32'h0000_0000;
            rx_pop_armed <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata       <= pwrite ? 32'h0000_0000 : read_value;
            rx_pop_armed <= !pwrite && hit_rx_data && rx_count != 5'h00;
        end
    end

    // ---------------------------------------------------------------
    // Thresholds and flow control
    // ---------------------------------------------------------------

    wire logic       flow_on    = fifo_control.flow_control_enable;
    wire logic       loop_on    = fifo_control.loopback_enable;
    wire logic [4:0] flow_level = FLOW_OFF_LEVEL[fifo_control.flow_off_trigger_sel];
    wire logic [4:0] rx_level   = RX_FLAG_LEVEL[fifo_control.rx_threshold_sel];
    wire logic [4:0] tx_level   = TX_FLAG_LEVEL[fifo_control.tx_threshold_sel];
    wire logic       rts_level  = flow_on && rx_count > flow_level;
    wire logic       cts_seen   = loop_on ? rts_level : cts_sync;

    assign rx_full_flag  = rx_count >= rx_level;
    assign tx_empty_flag = tx_count <= tx_level;
    assign tx_allowed    = !flow_on || !cts_seen;

    // ---------------------------------------------------------------
    // Pin multiplexing
    // ---------------------------------------------------------------

    // The receiver listens to the transmitter in loopback, never to the pin.
    assign rx_serial_out = loop_on ? tx_serial_in : rxd_sync;

    wire logic txd_forced = !transmitter_enable
                            && pin_port_control.txd_force_enable;

    assign txd_pin = txd_forced ? pin_port_control.txd_force_value
                   : loop_on    ? 1'b1
                   : tx_serial_in;

    assign rts_pin_out  = flow_on ? rts_level
                                  : pin_port_control.req_pin_value;
    assign rts_pin_oe_n = !(flow_on || pin_port_control.req_pin_drive_enable);

    assign cts_pin_out  = pin_port_control.clr_pin_value;
    assign cts_pin_oe_n = flow_on || !pin_port_control.clr_pin_drive_enable;

    assign sck_pin_out  = pin_port_control.clk_pin_value;
    assign sck_pin_oe_n = !(clk_source_sel == CLK_SRC_PORT
                            && pin_port_control.clk_pin_drive_enable);

endmodule // serial_fifo_port_control

// ===== include/serial_fifo_pkg.sv
// Contract
// - Request line rises when held count exceeds level.
// - Flow level codes map to 15,1,4,6,8,10,12,14.
// - Receive flag threshold codes map to 1,4,8,14.
// - Transmit flag threshold codes map to 8,4,2,1.
// - Control bit 3 enables request/clear flow control.
// - Control bit 2 holds transmit queue cleared.
// - Control bit 1 holds receive queue cleared.
// - Control bit 0 loops transmit and request internally.
// - Count bits 12-8 show untransmitted bytes, 0..16.
// - Count bits 4-0 show received bytes, 0..16.
// - Request/clear pin control only without flow control.
// - Clock pin control only with clock source 00.
// - Transmit pin control only with transmitter disabled.
// - Port bit 7 drives request pin with bit 6.
// - Port bit 5 drives clear pin with bit 4.
// - Port bit 3 drives clock pin with bit 2.
// - Port bit 1 drives transmit pin with bit 0.
// - Port bit 0 reads the receive pin level.
// - Reception into a full queue sets overrun.
// - Transmit queue holds 16; writes when full dropped.
// - Receive queue takes each completed byte, up to 16.
package serial_fifo_pkg;

    localparam logic [31:0] ADDR_TX_DATA       = 32'h0400_010c;
    localparam logic [31:0] ADDR_RX_DATA       = 32'h0400_0114;
    localparam logic [31:0] ADDR_FIFO_CONTROL  = 32'h0400_0118;
    localparam logic [31:0] ADDR_FILL_COUNT    = 32'h0400_011c;
    localparam logic [31:0] ADDR_PORT_CONTROL  = 32'h0400_0120;
    localparam logic [31:0] ADDR_LINE_STATUS   = 32'h0400_0124;

    localparam logic [15:0] FIFO_CONTROL_RESET = 16'h0060;
    localparam logic [15:0] PORT_CONTROL_RESET = 16'h0060;

    localparam int          FIFO_DEPTH         = 16;
    localparam int          PTR_WIDTH          = 4;
    localparam logic [4:0]  FIFO_FULL_COUNT    = 5'h10;
    localparam logic [1:0]  CLK_SRC_PORT       = 2'h0;

    localparam int          TX_COUNT_LSB       = 8;
    localparam int          RX_COUNT_LSB       = 0;
    localparam int          OVERRUN_BIT        = 0;

    localparam logic [4:0]  FLOW_OFF_LEVEL [8] = '{5'd15, 5'd1, 5'd4, 5'd6,
                                                  5'd8, 5'd10, 5'd12, 5'd14};
    localparam logic [4:0]  RX_FLAG_LEVEL  [4] = '{5'd1, 5'd4, 5'd8, 5'd14};
    localparam logic [4:0]  TX_FLAG_LEVEL  [4] = '{5'd8, 5'd4, 5'd2, 5'd1};

    typedef struct packed {
        logic [4:0] unused;
        logic [2:0] flow_off_trigger_sel;
        logic [1:0] rx_threshold_sel;
        logic [1:0] tx_threshold_sel;
        logic       flow_control_enable;
        logic       tx_fifo_clear;
        logic       rx_fifo_clear;
        logic       loopback_enable;
    } fifo_control_type;

    typedef struct packed {
        logic [7:0] unused;
        logic       req_pin_drive_enable;
        logic       req_pin_value;
        logic       clr_pin_drive_enable;
        logic       clr_pin_value;
        logic       clk_pin_drive_enable;
        logic       clk_pin_value;
        logic       txd_force_enable;
        logic       txd_force_value;
    } pin_port_control_type;

endpackage

// ===== rtl/byte_fifo_mem.sv
module byte_fifo_mem
    import serial_fifo_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 write_en,
    input  wire logic [PTR_WIDTH-1:0] write_addr,
    input  wire logic [7:0]           write_data,
    input  wire logic [PTR_WIDTH-1:0] read_addr,
    output logic      [7:0]           read_data
);

    logic [7:0] store [FIFO_DEPTH];

    // A write to the entry being read is forwarded so the head is never stale.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < FIFO_DEPTH; i++)
            begin
                store[i] <= 8'h00;
            end
            read_data <= 8'h00;
        end
        else
        begin
            if (write_en)
            begin
                store[write_addr] <= write_data;
            end
            read_data <= (write_en && write_addr == read_addr) ? write_data
                                                                : store[read_addr];
        end
    end

endmodule // byte_fifo_mem

// ===== tb/serial_fifo_port_control_chk.sv
module serial_fifo_chk
    import serial_fifo_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        transmitter_enable,
    input wire logic [1:0]  clk_source_sel,
    input wire logic        tx_serial_in,
    input wire logic        rx_serial_out,
    input wire logic        txd_pin,
    input wire logic        rts_pin_out,
    input wire logic        rts_pin_oe_n,
    input wire logic        cts_pin_out,
    input wire logic        cts_pin_oe_n,
    input wire logic        sck_pin_out,
    input wire logic        sck_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // Shadow copies of the low control bytes
    // ----
    logic [7:0] ctl;
    logic [7:0] port;
    wire        wr_low = psel && penable && pwrite && pstrb[0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl  <= FIFO_CONTROL_RESET[7:0];
            port <= PORT_CONTROL_RESET[7:0];
        end
        else if (wr_low)
        begin
            if (paddr == ADDR_FIFO_CONTROL)
                ctl <= pwdata[7:0];
            if (paddr == ADDR_PORT_CONTROL)
                port <= pwdata[7:0];
        end
    end

    // ----
    // Pin and bus relations
    // ----
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_rts_port_drive: assert property (
        !ctl[3] && port[7] |-> !rts_pin_oe_n && rts_pin_out == port[6])
        else $error("request pin not driven from port bits");
    a_cts_port_drive: assert property (
        !ctl[3] && port[5] |-> !cts_pin_oe_n && cts_pin_out == port[4])
        else $error("clear pin not driven from port bits");
    a_sck_port_drive: assert property (
        clk_source_sel == CLK_SRC_PORT && port[3] |-> !sck_pin_oe_n && sck_pin_out == port[2])
        else $error("clock pin not driven from port bits");
    a_sck_other_src: assert property (
        clk_source_sel != CLK_SRC_PORT |-> sck_pin_oe_n)
        else $error("clock pin driven outside port mode");
    a_txd_port_force: assert property (
        !transmitter_enable && port[1] && !ctl[0] |-> txd_pin == port[0])
        else $error("transmit pin not forced");
    a_txd_follows_tx: assert property (
        (transmitter_enable || !port[1]) && !ctl[0] |-> txd_pin == tx_serial_in)
        else $error("transmit pin not following shifter");
    a_txd_loop_idle: assert property (
        ctl[0] && (transmitter_enable || !port[1]) |-> txd_pin)
        else $error("transmit pin not idle in loopback");
    a_loop_rx_path: assert property (
        ctl[0] |-> rx_serial_out == tx_serial_in)
        else $error("loopback path broken");
    a_flow_pins: assert property (
        ctl[3] && !ctl[0] |-> !rts_pin_oe_n && cts_pin_oe_n)
        else $error("flow control pins wrong");
    a_rdata_hold: assert property (
        psel && penable |=> $stable(prdata))
        else $error("read data changed after access");
endmodule // serial_fifo_chk

bind serial_fifo_port_control serial_fifo_chk u_chk (.*);

// ===== tb/remote_serial_port.sv
module remote_serial_port
(
    input  wire logic       pclk,
    input  wire logic       send_req,
    input  wire logic [7:0] send_byte,
    input  wire logic       hold_low,
    input  wire logic       stall,
    output logic            rxd_pin,
    output logic            cts_pin_in,
    output logic            rx_done,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----
    // Far side line and finished-frame strobe
    // ----
    initial
    begin
        rxd_pin    = 1'b1;
        cts_pin_in = 1'b0;
        rx_done    = 1'b0;
        rx_byte    = 8'h00;
    end

    // Between frames the byte lines toggle so a stale byte never looks fresh.
    always @(posedge pclk)
    begin
        rxd_pin    <= !(send_req || hold_low);
        cts_pin_in <= stall;
        rx_done    <= send_req;
        rx_byte    <= send_req ? send_byte : ~rx_byte;
    end
endmodule // remote_serial_port

// ===== tb/serial_fifo_port_control_test.sv
module serial_fifo_port_control_test
    import serial_fifo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [1:0]  clk_source_sel;
    logic [7:0]  tx_byte, rx_byte, send_byte;
    logic        transmitter_enable, tx_serial_in, tx_take, tx_byte_valid, tx_allowed;
    logic        rx_done, rx_serial_out, rx_full_flag, tx_empty_flag, rxd_pin, txd_pin;
    logic        rts_pin_out, rts_pin_oe_n, cts_pin_in, cts_pin_out, cts_pin_oe_n;
    logic        sck_pin_out, sck_pin_oe_n, send_req, hold_low, stall;
    logic [15:0] cv;
    int          error_cnt, check_count;
    int          TL [4] = '{8, 4, 2, 1};
    int          RL [4] = '{1, 4, 8, 14};
    int          FL [8] = '{15, 1, 4, 6, 8, 10, 12, 14};

    // Pin view: active-low enable, driven level (0 when released), transmit pin, receive path.
    wire [7:0]   pins = {rts_pin_oe_n, rts_pin_out & !rts_pin_oe_n, cts_pin_oe_n,
                         cts_pin_out & !cts_pin_oe_n, sck_pin_oe_n,
                         sck_pin_out & !sck_pin_oe_n, txd_pin, rx_serial_out};

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] port;
        logic       te;
        logic [1:0] cks;
        logic       tx;
        logic [7:0] exp;
    } pin_row_type;

    pin_row_type rows [7] = '{
        '{8'h60, 8'hAA, 1'b0, 2'h0, 1'b1, 8'h01}, '{8'h60, 8'hFF, 1'b0, 2'h0, 1'b0, 8'h57},
        '{8'h60, 8'hFE, 1'b1, 2'h1, 1'b1, 8'h5B}, '{8'h68, 8'hFF, 1'b0, 2'h0, 1'b1, 8'h27},
        '{8'h61, 8'h00, 1'b1, 2'h2, 1'b0, 8'hAA}, '{8'h61, 8'h00, 1'b1, 2'h0, 1'b1, 8'hAB},
        '{8'h60, 8'h00, 1'b1, 2'h0, 1'b0, 8'hA9}};

    serial_fifo_port_control u_dut (.*);
    remote_serial_port       u_far (.*);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----
    // Shared tasks
    // ----
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        q = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, e);
    endtask

    task automatic rx_push(input logic [7:0] b);
        @(posedge pclk);
        send_req  <= 1'b1;
        send_byte <= b;
        @(posedge pclk);
        send_req  <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        {presetn, psel, penable, pwrite, send_req, hold_low, stall, tx_take} = '0;
        {paddr, pwdata, send_byte, transmitter_enable, clk_source_sel} = '0;
        {pstrb, tx_serial_in, error_cnt, check_count} = '1;
        {error_cnt, check_count} = '0;
        do_reset();
        foreach (rows[i])
        begin
            wr(ADDR_FIFO_CONTROL, {24'h0, rows[i].ctl});
            wr(ADDR_PORT_CONTROL, {24'h0, rows[i].port});
            transmitter_enable <= rows[i].te;
            clk_source_sel     <= rows[i].cks;
            tx_serial_in       <= rows[i].tx;
            @(posedge pclk);
            #1;
            chk({24'h0, pins}, {24'h0, rows[i].exp});
        end
        hold_low <= 1'b1;
        do_reset();
        #1;
        chk_bit(rx_full_flag, 1'b0);
        chk_bit(tx_empty_flag, 1'b1);
        rd(ADDR_FIFO_CONTROL, 32'h0000_0060);
        rd(ADDR_FILL_COUNT, 32'h0000_0000);
        rd(ADDR_PORT_CONTROL, 32'h0000_0060);
        rd(ADDR_LINE_STATUS, 32'h0000_0000);
        hold_low <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(ADDR_PORT_CONTROL, 32'h0000_0061);
        for (int k = 0; k < 4; k++)
        begin
            cv = {10'h0, k[1:0], 4'h4};
            wr(ADDR_FIFO_CONTROL, {16'h0, cv});
            rd(ADDR_FILL_COUNT, 32'h0000_0000);
            wr(ADDR_FIFO_CONTROL, {16'h0, cv & 16'hFFFB});
            for (int c = 1; c <= TL[k] + 1; c++)
            begin
                wr(ADDR_TX_DATA, 32'(c));
                @(posedge pclk);
                #1;
                chk_bit(tx_empty_flag, c <= TL[k]);
            end
        end
        wr(ADDR_FIFO_CONTROL, 32'h0000_0004);
        wr(ADDR_FIFO_CONTROL, 32'h0000_0000);
        for (int c = 0; c < 17; c++)
            wr(ADDR_TX_DATA, 32'h0000_00A0 + 32'(c));
        @(posedge pclk);
        #1;
        chk_bit(tx_byte_valid, 1'b1);
        chk({24'h0, tx_byte}, 32'h0000_00A0);
        rd(ADDR_FILL_COUNT, 32'h0000_1000);
        tx_take <= 1'b1;
        @(posedge pclk);
        tx_take <= 1'b0;
        #1;
        chk({24'h0, tx_byte}, 32'h0000_00A1);
        for (int k = 0; k < 8; k++)
        begin
            cv = {5'h0, k[2:0], k[1:0], 2'h0, 4'hE};
            wr(ADDR_FIFO_CONTROL, {16'h0, cv});
            rd(ADDR_FILL_COUNT, 32'h0000_0000);
            cv[2:1] = 2'b00;
            wr(ADDR_FIFO_CONTROL, {16'h0, cv});
            for (int c = 1; c <= 16; c++)
            begin
                rx_push(8'(c));
                chk_bit(rts_pin_out, c > FL[k]);
                chk_bit(rx_full_flag, c >= RL[k % 4]);
            end
            rd(ADDR_FILL_COUNT, 32'h0000_0010);
        end
        wr(ADDR_FIFO_CONTROL, {16'h0, cv | 16'h0001});
        #1;
        chk_bit(tx_allowed, 1'b0);
        wr(ADDR_FIFO_CONTROL, {16'h0, cv});
        #1;
        chk_bit(tx_allowed, 1'b1);
        stall <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        chk_bit(tx_allowed, 1'b0);
        stall <= 1'b0;
        rx_push(8'h55);
        rd(ADDR_FILL_COUNT, 32'h0000_0010);
        wr(ADDR_LINE_STATUS, 32'h0000_0000);
        rd(ADDR_LINE_STATUS, 32'h0000_0001);
        wr(ADDR_LINE_STATUS, 32'h0000_0000);
        rd(ADDR_LINE_STATUS, 32'h0000_0000);
        rd(ADDR_RX_DATA, 32'h0000_0001);
        rd(ADDR_FILL_COUNT, 32'h0000_000F);
        rd(32'h0400_0128, 32'h0000_0000);
        chk_bit(perr, 1'b1);
        complete_run();
    end
endmodule // serial_fifo_port_control_test
